/* logic/jps_defs.vh */
// Overview of operation
// - Five TCK cycles with TMS high and TDI low force the target TAP into its reset state.
// - One TCK cycle with TMS low and TDI low then moves the target TAP into idle.
// - Two TCK cycles with TMS high and TDI low advance the target TAP into the IR scan branch.
// - Two TCK cycles with TMS low and TDI low place the target TAP in Shift-IR.
// - A 32-bit signature is shifted on TDI least significant bit first with TMS low throughout.
// - 240 cycles follow with TDI high, TMS low except high on the last of them.
// - One final TCK cycle with TMS high and TDI low moves the target TAP into Update-IR.
// - TDO is watched during the shift for the returned signature to derive the IR length.
// - TDO is ignored during the first 10 TCK cycles because the target output may float.
// - TMS and TDI change on the falling edge of TCK so they are stable at the rising edge.
// - TCK is never generated faster than 12 MHz.
`ifndef JPS_DEFS_VH
`define JPS_DEFS_VH

`define JPS_RESET_CYC    9'd5
`define JPS_IDLE_CYC     9'd1
`define JPS_SCAN_CYC     9'd2
`define JPS_SHIFT_CYC    9'd2
`define JPS_SIG_CYC      9'd32
`define JPS_FILL_CYC     9'd240
`define JPS_UPDATE_CYC   9'd1
`define JPS_TDO_IGNORE   9'd10
`define JPS_REF_HZ       10000000
`define JPS_TCK_MAX_HZ   12000000
// The default signature value is arbitrary; any word the target cannot echo by chance will do.
`define JPS_SIG_DEFAULT  32'h5A5AC3C3
`define JPS_HALF_DEFAULT 16'd4

`endif

/* logic/jps_sig_window.v */
`timescale 1ns/1ps
`include "jps_defs.vh"

// Sliding window of recently sampled TDO bits with a signature compare.
module jps_sig_window #(
  parameter WIDTH = 32
) (
  input  wire             ref_clk,
  input  wire             reset,
  input  wire             clk_en,
  input  wire             shift_en,
  input  wire             bit_in,
  input  wire [WIDTH-1:0] sig,
  output reg              match_r
);

  reg [WIDTH-1:0] win_r;
  wire [WIDTH-1:0] win_nxt;

  // Bits arrive lsb first, so new bits enter at the top and older ones move down.
  assign win_nxt = {bit_in, win_r[WIDTH-1:1]};

  // The compare is registered so the match lines up one cycle after the shift.
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      win_r   <= {WIDTH{1'b0}};
      match_r <= 1'b0;
    end
    else if (clk_en)
    begin
      match_r <= 1'b0;
      if (shift_en)
      begin
        win_r   <= win_nxt;
        match_r <= (win_nxt == sig);
      end
    end
  end

endmodule // jps_sig_window

/* logic/jps_start_seq.v */
`timescale 1ns/1ps
`include "jps_defs.vh"

// Probe-side start-up sequencer: walks the target TAP to Shift-IR, shifts a
// signature and a run of ones, exits to Update-IR and measures the IR length.
module jps_start_seq #(
  parameter [15:0] HALF_PER = `JPS_HALF_DEFAULT,
  parameter [31:0] SIG      = `JPS_SIG_DEFAULT
) (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire        clk_en,
  input  wire        start,
  input  wire        tdo,
  output reg         tck_r,
  output reg         tms_r,
  output reg         tdi_r,
  output reg         busy_r,
  output reg         done_r,
  output reg         found_r,
  output reg  [8:0]  ir_len_r
);

  // Half period must give TCK no faster than the allowed maximum.
  localparam [31:0] HALF_MIN_W = (`JPS_REF_HZ + 2 * `JPS_TCK_MAX_HZ - 1) / (2 * `JPS_TCK_MAX_HZ);
  localparam [15:0] HALF_MIN   = HALF_MIN_W[15:0];
  localparam [15:0] HALF     = (HALF_PER < HALF_MIN) ? HALF_MIN : HALF_PER;
  localparam [15:0] HALF_ONE = (HALF == 16'd0) ? 16'd1 : HALF;

  localparam [2:0] ST_IDLE   = 3'd0;
  localparam [2:0] ST_RESET  = 3'd1;
  localparam [2:0] ST_RTI    = 3'd2;
  localparam [2:0] ST_SCAN   = 3'd3;
  localparam [2:0] ST_SHIFT  = 3'd4;
  localparam [2:0] ST_SIG    = 3'd5;
  localparam [2:0] ST_FILL   = 3'd6;
  localparam [2:0] ST_UPDATE = 3'd7;

  reg [2:0]  state_r;
  reg [8:0]  cnt_r;
  reg [15:0] div_r;
  reg [8:0]  total_r;
  reg [8:0]  since_r;
  reg        tdo_s1_r;
  reg        tdo_s2_r;
  reg        rise_r;
  reg        seen_r;
  reg        state_done;
  reg [2:0]  next_state;
  reg        tms_nxt;
  reg        tdi_nxt;
  wire       half_tick;
  wire       fall_tick;
  wire       match;

  assign half_tick = busy_r && (div_r == HALF_ONE - 16'd1);
  assign fall_tick = half_tick && tck_r;

  // TDO comes from another chip, so it passes two flops before use.
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      tdo_s1_r <= 1'b0;
      tdo_s2_r <= 1'b0;
    end
    else if (clk_en)
    begin
      tdo_s1_r <= tdo;
      tdo_s2_r <= tdo_s1_r;
    end
  end

  // Phase length and the pin levels that each phase drives.
  always @*
  begin
    state_done = 1'b0;
    next_state = state_r;
    tms_nxt    = 1'b0;
    tdi_nxt    = 1'b0;
    case (state_r)
      ST_RESET:
      begin
        state_done = (cnt_r == `JPS_RESET_CYC - 9'd1);
        next_state = ST_RTI;
      end
      ST_RTI:
      begin
        state_done = (cnt_r == `JPS_IDLE_CYC - 9'd1);
        next_state = ST_SCAN;
      end
      ST_SCAN:
      begin
        state_done = (cnt_r == `JPS_SCAN_CYC - 9'd1);
        next_state = ST_SHIFT;
      end
      ST_SHIFT:
      begin
        state_done = (cnt_r == `JPS_SHIFT_CYC - 9'd1);
        next_state = ST_SIG;
      end
      ST_SIG:
      begin
        state_done = (cnt_r == `JPS_SIG_CYC - 9'd1);
        next_state = ST_FILL;
      end
      ST_FILL:
      begin
        state_done = (cnt_r == `JPS_FILL_CYC - 9'd1);
        next_state = ST_UPDATE;
      end
      ST_UPDATE:
      begin
        state_done = (cnt_r == `JPS_UPDATE_CYC - 9'd1);
        next_state = ST_IDLE;
      end
      default:
      begin
        state_done = 1'b0;
        next_state = ST_IDLE;
      end
    endcase
    // Levels for the cycle about to start after a phase change.
    case (state_done ? next_state : state_r)
      ST_RESET:  tms_nxt = 1'b1;
      ST_RTI:    tms_nxt = 1'b0;
      ST_SCAN:   tms_nxt = 1'b1;
      ST_SHIFT:  tms_nxt = 1'b0;
      ST_SIG:
      begin
        tms_nxt = 1'b0;
        tdi_nxt = SIG[state_done ? 5'd0 : cnt_r[4:0] + 5'd1];
      end
      ST_FILL:
      begin
        tdi_nxt = 1'b1;
        tms_nxt = !state_done && (cnt_r == `JPS_FILL_CYC - 9'd2);
      end
      ST_UPDATE: tms_nxt = 1'b1;
      default:   tms_nxt = 1'b0;
    endcase
  end

  // TCK divider and sequencer; pins move only on the falling TCK edge.
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= 9'd0;
      div_r   <= 16'd0;
      tck_r   <= 1'b0;
      tms_r   <= 1'b1;
      tdi_r   <= 1'b0;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
    end
    else if (clk_en)
    begin
      done_r <= 1'b0;
      if (!busy_r)
      begin
        if (start)
        begin
          busy_r  <= 1'b1;
          state_r <= ST_RESET;
          cnt_r   <= 9'd0;
          div_r   <= 16'd0;
          tms_r   <= 1'b1;
          tdi_r   <= 1'b0;
        end
      end
      else if (half_tick)
      begin
        div_r <= 16'd0;
        tck_r <= !tck_r;
        if (tck_r)
        begin
          if (state_done && next_state == ST_IDLE)
          begin
            busy_r  <= 1'b0;
            done_r  <= 1'b1;
            state_r <= ST_IDLE;
            tms_r   <= 1'b1;
            tdi_r   <= 1'b0;
          end
          else
          begin
            state_r <= state_done ? next_state : state_r;
            cnt_r   <= state_done ? 9'd0 : cnt_r + 9'd1;
            tms_r   <= tms_nxt;
            tdi_r   <= tdi_nxt;
          end
        end
      end
      else
        div_r <= div_r + 16'd1;
    end
  end

  // Rising TCK edge marks where TDO is sampled, as the target would see it.
  always @(posedge ref_clk)
  begin
    if (reset)
      rise_r <= 1'b0;
    else if (clk_en)
      rise_r <= half_tick && !tck_r;
  end

  // Count TCK cycles, and the cycles since the first signature bit went out.
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      total_r  <= 9'd0;
      since_r  <= 9'd0;
      seen_r   <= 1'b0;
      found_r  <= 1'b0;
      ir_len_r <= 9'd0;
    end
    else if (clk_en)
    begin
      if (start && !busy_r)
      begin
        total_r  <= 9'd0;
        since_r  <= 9'd0;
        seen_r   <= 1'b0;
        found_r  <= 1'b0;
        ir_len_r <= 9'd0;
      end
      else if (fall_tick)
      begin
        if (total_r != 9'h1FF)
          total_r <= total_r + 9'd1;
        if (state_r == ST_SIG || state_r == ST_FILL)
          since_r <= since_r + 9'd1;
      end
      if (match && !seen_r && busy_r)
      begin
        seen_r   <= 1'b1;
        found_r  <= 1'b1;
        // The count spans the 31 later signature bits plus the echo delay.
        ir_len_r <= since_r - `JPS_SIG_CYC + 9'd1;
      end
    end
  end

  // Window only accepts TDO once the undefined opening cycles have passed.
  jps_sig_window #(
    .WIDTH (32)
  ) u_win (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .shift_en (rise_r && (total_r >= `JPS_TDO_IGNORE)),
    .bit_in   (tdo_s2_r),
    .sig      (SIG),
    .match_r  (match)
  );

endmodule // jps_start_seq

/* tb/jps_start_seq_props.sv */
`timescale 1ns/1ps
module jps_start_seq_props (
  input wire       ref_clk,
  input wire       reset,
  input wire       clk_en,
  input wire       start,
  input wire       tdo,
  input wire       tck_r,
  input wire       tms_r,
  input wire       tdi_r,
  input wire       busy_r,
  input wire       done_r,
  input wire       found_r,
  input wire [8:0] ir_len_r
);
  // All checks share the reference clock and pause while reset is high.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_idle_levels: assert property (!busy_r && !done_r |-> !tck_r && tms_r && !tdi_r)
    else $error("idle pin levels wrong");
  a_start_taken: assert property (start && clk_en && !busy_r |=> busy_r)
    else $error("start not taken");
  a_tms_on_fall: assert property ($changed(tms_r) |-> $fell(tck_r))
    else $error("tms moved off a tck fall");
  a_tdi_on_fall: assert property ($changed(tdi_r) |-> $fell(tck_r))
    else $error("tdi moved off a tck fall");
  a_tck_high_min: assert property ($rose(tck_r) |=> tck_r [*3])
    else $error("tck high phase too short");
  a_done_one_cycle: assert property (done_r && clk_en |=> !done_r)
    else $error("done longer than a cycle");
  a_done_levels: assert property (done_r |-> !tck_r && tms_r && !tdi_r)
    else $error("end pin levels wrong");
  a_found_len: assert property (found_r && done_r |-> ir_len_r == 9'd4)
    else $error("ir length wrong");
endmodule // jps_start_seq_props

/* tb/jps_tap_model.sv */
`timescale 1ns/1ps
module jps_tap_model #(
  parameter IRLEN = 4
) (
  input  wire tck,
  input  wire tms,
  input  wire tdi,
  input  wire mute,
  output reg  tdo
);
  // Next TAP state for TMS low and high, one nibble per state; 4'hA captures, 4'hB shifts IR.
  localparam [63:0] NXT0 = 64'h1BDDBBA146644311;
  localparam [63:0] NXT1 = 64'h2FEFCC0287855920;
  reg [3:0]       st_r = 4'h0;
  reg [IRLEN-1:0] ir_r = {IRLEN{1'b0}};
  initial tdo = 1'b0;

  // The IR path takes TDI at the rising edge, so a bit needs IRLEN edges to reach TDO.
  always @(posedge tck)
  begin
    if (st_r == 4'hB)
      ir_r <= {tdi, ir_r[IRLEN-1:1]};
    else if (st_r == 4'hA)
      ir_r <= {{(IRLEN-1){1'b0}}, 1'b1};
    st_r <= tms ? NXT1[4*st_r +: 4] : NXT0[4*st_r +: 4];
  end

  // Outside Shift-IR the pin floats, so it toggles rather than keep a stale level.
  always @(negedge tck)
    tdo <= (st_r == 4'hB && !mute) ? ir_r[0] : !tdo;
endmodule // jps_tap_model

/* tb/jps_start_seq_bench.sv */
`timescale 1ns/1ps
`include "jps_defs.vh"
module jps_start_seq_bench;
  localparam [31:0] SIG_W = `JPS_SIG_DEFAULT;
  reg        ref_clk = 1'b0;
  reg        reset = 1'b1;
  reg        clk_en = 1'b1;
  reg        start = 1'b0;
  reg        mute = 1'b0;
  wire       tdo, tck_r, tms_r, tdi_r, busy_r, done_r, found_r;
  wire [8:0] ir_len_r;
  integer    n_errors = 0;
  integer    n_checks = 0;
  integer    k;
  reg  [1:0] got_q [$];

  jps_start_seq u_jps_start_seq (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .start(start), .tdo(tdo), .tck_r(tck_r), .tms_r(tms_r), .tdi_r(tdi_r),
    .busy_r(busy_r), .done_r(done_r), .found_r(found_r), .ir_len_r(ir_len_r));
  jps_tap_model u_jps_tap_model (.tck(tck_r), .tms(tms_r), .tdi(tdi_r), .mute(mute),
    .tdo(tdo));

  // The clock flips every 50 ns.
  always #50 ref_clk = ~ref_clk;

  // Record the levels the target samples at each TCK rise.
  always @(posedge tck_r)
    got_q.push_back({tms_r, tdi_r});

  task chk(input [63:0] nm, input [8:0] e, input [8:0] g);
  begin
    n_checks = n_checks + 1;
    if (g !== e)
    begin
      n_errors = n_errors + 1;
      $display("mismatch %0s expected %0h seen %0h", nm, e, g);
    end
  end
  endtask

  // Reference model of TMS and TDI at TCK rise i.
  function [1:0] exp_pins(input integer i);
  begin
    exp_pins[1] = i < 5 || (i > 5 && i < 8) || i > 280;
    exp_pins[0] = (i >= 10 && i < 42) ? SIG_W[i-10] : (i >= 42 && i < 282);
  end
  endfunction

  // One start; start is held a while so a busy sequencer must refuse it.
  task run(input m);
  begin
    @(negedge ref_clk);
    mute = m;
    got_q.delete();
    start = 1'b1;
    clk_en = 1'b1;
    k = 0;
    while (done_r !== 1'b1 && k < 20000)
    begin
      @(negedge ref_clk);
      if (k == 20)
        start = 1'b0;
      clk_en = $urandom % 4 != 0;
      k = k + 1;
    end
    // A sequence that never ends is a failure in its own right.
    if (k == 20000)
    begin
      n_errors = n_errors + 1;
      stop_test;
    end
    clk_en = 1'b1;
    chk("count", 9'd283, 9'(got_q.size()));
    for (k = 0; k < 283 && k < got_q.size(); k = k + 1)
      chk("pins", {7'd0, exp_pins(k)}, {7'd0, got_q[k]});
    chk("found", {8'd0, !m}, {8'd0, found_r});
    if (!m)
      chk("ir_len", 9'd4, ir_len_r);
  end
  endtask

  task stop_test;
  begin
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask

  // Runs with and without a target echo, and a reset in mid-sequence.
  initial
  begin
    k = $urandom(32'h22D2);
    repeat (10) @(negedge ref_clk);
    reset = 1'b0;
    run(1'b0);
    @(negedge ref_clk);
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    repeat (60 + $urandom % 200) @(negedge ref_clk);
    // Two reset edges, so the sampled-value checks restart from settled levels.
    reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    chk("idle", 9'h008, {4'd0, tck_r, tms_r, tdi_r, busy_r, found_r});
    run(1'b1);
    run(1'b0);
    stop_test;
  end
endmodule // jps_start_seq_bench

bind jps_start_seq jps_start_seq_props u_props (.ref_clk(ref_clk), .reset(reset),
  .clk_en(clk_en), .start(start), .tdo(tdo), .tck_r(tck_r), .tms_r(tms_r), .tdi_r(tdi_r),
  .busy_r(busy_r), .done_r(done_r), .found_r(found_r), .ir_len_r(ir_len_r));
